//--- logic/msp_phase_avg.sv
// Averager of sync phase samples over a window of 2**code samples.
// Assumes samples come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module msp_phase_avg import msp_pkg::*; (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_clear,
  input wire logic i_sample_vld,
  input wire logic [PHASE_W-1:0] i_sample,
  input wire logic [AVG_W-1:0] i_code,
  output logic o_avg_vld,
  output logic [RB_W-1:0] o_avg
);
  logic [SUM_W-1:0] acc;
  logic [CNT_W-1:0] cnt;
  logic [SUM_W-1:0] next_acc;
  logic [CNT_W-1:0] window;
  logic [SUM_W+FRAC_W-1:0] scaled;
  logic window_done;

  assign next_acc = acc + SUM_W'(i_sample);
  assign window = CNT_W'(1) << i_code;
  // A code lowered mid-window must still close it, hence the compare by size.
  assign window_done = i_sample_vld && ((cnt + CNT_W'(1)) >= window);
  // Sum times four over the count keeps two fractional bits.
  assign scaled = {next_acc, 2'b00} >> i_code;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      acc <= '0;
      cnt <= '0;
    end else if (i_clear || window_done) begin
      acc <= '0;
      cnt <= '0;
    end else if (i_sample_vld) begin
      acc <= next_acc;
      cnt <= cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_avg_vld <= 1'b0;
      o_avg <= '0;
    end else begin
      o_avg_vld <= window_done && !i_clear;
      if (window_done) begin
        o_avg <= scaled[RB_W-1:0];
      end
    end
  end

  AST_AVG_SINGLE: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_sample_vld && !i_clear && (i_code == 3'h0) |=> o_avg_vld && (o_avg == {$past(i_sample), 2'b00}))
    else $error("single sample average wrong");
  AST_AVG_WINDOW: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_avg_vld && ($past(i_code) == 3'h2) |-> $past(cnt) == 8'h03)
    else $error("window of four closed early");
endmodule // msp_phase_avg
`default_nettype wire

//--- logic/msp_pkg.sv
// Constants, register map and carrier types of the sync phase monitor.
// Assumes one 200 MHz sample clock and an 8-bit register port.
package msp_pkg;
  // ==========================================================================
  // Widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PHASE_W = 6;
  localparam int unsigned FRAC_W = 2;
  localparam int unsigned RB_W = 8;
  localparam int unsigned AVG_W = 3;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned SUM_W = 13;
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned LVL_FLAGS = 6;
  localparam int unsigned LANES_PAIR = 2;
  localparam int unsigned LANES_DATA = 16;
  // ==========================================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_SYNC_CTRL = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_PHASE_REQ = 8'h11;
  localparam logic [ADDR_W-1:0] OFF_LOCK_STAT = 8'h12;
  localparam logic [ADDR_W-1:0] OFF_PHASE_RB = 8'h13;
  localparam logic [ADDR_W-1:0] OFF_LEVEL_STAT = 8'h15;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h31;
  // ==========================================================================
  // Reset values
  localparam logic [DATA_W-1:0] RST_SYNC_CTRL = 8'h48;
  localparam logic [PHASE_W-1:0] RST_PHASE_REQ = 6'h00;
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 4'h0;
  // ==========================================================================
  // Field positions
  localparam int unsigned CTL_EN_BIT = 7;
  localparam int unsigned CTL_RATE_BIT = 6;
  localparam int unsigned CTL_RISE_BIT = 3;
  localparam int unsigned STAT_LOST_BIT = 7;
  localparam int unsigned STAT_LOCK_BIT = 6;
  localparam int unsigned IRQ_LOCK_BIT = 0;
  localparam int unsigned IRQ_LOST_BIT = 1;
  localparam int unsigned IRQ_RB_BIT = 2;
  localparam int unsigned IRQ_LVL_BIT = 3;
  // ==========================================================================
  // Types
  typedef enum logic [1:0] {LK_IDLE, LK_LOCKED, LK_LOST} msp_lock_e;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } msp_bus_req_s;
  typedef struct packed {
    logic [LANES_PAIR-1:0] frame_hi;
    logic [LANES_PAIR-1:0] frame_lo;
    logic [LANES_PAIR-1:0] dclk_hi;
    logic [LANES_PAIR-1:0] dclk_lo;
    logic [LANES_DATA-1:0] data_hi;
    logic [LANES_DATA-1:0] data_lo;
  } msp_level_s;
  localparam int unsigned LVL_W = $bits(msp_level_s);
endpackage

//--- logic/msp_top.sv
// Multi-chip sync phase monitor: sync edge capture, phase alignment,
// lock tracking, averaged phase readback and input level fault flags.
// Assumes the sync pin and comparator flags are asynchronous to i_clk.
//
// Local design decision: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module msp_top import msp_pkg::*; (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire msp_bus_req_s i_bus,
  output logic [DATA_W-1:0] o_rdata,
  output logic o_irq,
  input wire logic i_sync,
  input wire msp_level_s i_level,
  output logic o_frame_strobe,
  output logic o_sync_locked
);
  // ==========================================================================
  // Input synchronisers
  logic sync_s1;
  logic sync_s2;
  logic sync_s3;
  logic [LVL_W-1:0] lvl_s1;
  logic [LVL_W-1:0] lvl_s2;
  msp_level_s level_q;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync_s1 <= 1'b0;
      sync_s2 <= 1'b0;
      sync_s3 <= 1'b0;
    end else begin
      sync_s1 <= i_sync;
      sync_s2 <= sync_s1;
      sync_s3 <= sync_s2;
    end
  end

  for (genvar g = 0; g < LVL_W; g++) begin : g_lvl_sync
    always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        lvl_s1[g] <= 1'b0;
        lvl_s2[g] <= 1'b0;
      end else begin
        lvl_s1[g] <= i_level[g];
        lvl_s2[g] <= lvl_s1[g];
      end
    end
  end

  assign level_q = lvl_s2;

  // ==========================================================================
  // Control registers
  logic sync_en;
  logic rate_sel;
  logic rise_sel;
  logic [AVG_W-1:0] avg_code;
  logic [PHASE_W-1:0] phase_req;
  logic [IRQ_W-1:0] irq_mask;
  logic wr_ctrl;
  logic wr_req;
  logic wr_mask;

  assign wr_ctrl = i_bus.wr && (i_bus.addr == OFF_SYNC_CTRL);
  assign wr_req = i_bus.wr && (i_bus.addr == OFF_PHASE_REQ);
  assign wr_mask = i_bus.wr && (i_bus.addr == OFF_IRQ_MASK);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync_en <= RST_SYNC_CTRL[CTL_EN_BIT];
      rate_sel <= RST_SYNC_CTRL[CTL_RATE_BIT];
      rise_sel <= RST_SYNC_CTRL[CTL_RISE_BIT];
      avg_code <= RST_SYNC_CTRL[AVG_W-1:0];
    end else if (wr_ctrl) begin
      sync_en <= i_bus.wdata[CTL_EN_BIT];
      rate_sel <= i_bus.wdata[CTL_RATE_BIT];
      rise_sel <= i_bus.wdata[CTL_RISE_BIT];
      avg_code <= i_bus.wdata[AVG_W-1:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      phase_req <= RST_PHASE_REQ;
    end else if (wr_req) begin
      phase_req <= i_bus.wdata[PHASE_W-1:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_mask <= RST_IRQ_MASK;
    end else if (wr_mask) begin
      irq_mask <= i_bus.wdata[IRQ_W-1:0];
    end
  end

  // ==========================================================================
  // Sync edge selection
  logic sync_rise;
  logic sync_fall;
  logic sync_edge;

  assign sync_rise = sync_s2 && !sync_s3;
  assign sync_fall = !sync_s2 && sync_s3;
  assign sync_edge = sync_en && (rise_sel ? sync_rise : sync_fall);

  // ==========================================================================
  // Lock state
  msp_lock_e lock_state;
  msp_lock_e next_lock_state;
  logic avg_vld;
  logic [RB_W-1:0] avg_val;
  logic phase_miss;

  // The request is compared at the averaged level, so even with averaging selected a single
  // sync edge one cycle off counts as a loss of lock, except a late one within a window of eight or more.
  assign phase_miss = avg_vld && (avg_val != {phase_req, 2'b00});

  always_comb begin
    next_lock_state = lock_state;
    case (lock_state)
      LK_IDLE: begin
        if (sync_edge) begin
          next_lock_state = LK_LOCKED;
        end
      end
      LK_LOCKED: begin
        if (phase_miss) begin
          next_lock_state = LK_LOST;
        end
      end
      LK_LOST: begin
        next_lock_state = LK_LOST;
      end
      default: begin
        next_lock_state = LK_IDLE;
      end
    endcase
    if (!sync_en) begin
      next_lock_state = LK_IDLE;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      lock_state <= LK_IDLE;
    end else begin
      lock_state <= next_lock_state;
    end
  end

  // ==========================================================================
  // Phase counter and output frame
  logic [PHASE_W-1:0] phase_cnt;

  // Loading the request at the sync edge makes the frame strobe fire a
  // requested number of cycles earlier than on an unskewed converter.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      phase_cnt <= '0;
    end else if (sync_edge && (lock_state == LK_IDLE)) begin
      phase_cnt <= phase_req;
    end else begin
      phase_cnt <= phase_cnt + 6'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_frame_strobe <= 1'b0;
    end else begin
      o_frame_strobe <= (phase_cnt == 6'h00);
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sync_locked <= 1'b0;
    end else begin
      o_sync_locked <= (next_lock_state == LK_LOCKED);
    end
  end

  // ==========================================================================
  // Phase averaging and readback
  logic sample_vld;
  logic [RB_W-1:0] phase_rb;
  logic [PHASE_W-1:0] phase_at_edge;

  assign sample_vld = sync_edge && (lock_state == LK_LOCKED);
  // The counter takes this value at the edge that sees the sync, so it is the phase;
  // sampling the counter itself would read one cycle short and report a false loss.
  assign phase_at_edge = phase_cnt + 6'h01;

  msp_phase_avg u_avg (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_clear(lock_state != LK_LOCKED),
    .i_sample_vld(sample_vld),
    .i_sample(phase_at_edge),
    .i_code(avg_code),
    .o_avg_vld(avg_vld),
    .o_avg(avg_val)
  );

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      phase_rb <= '0;
    end else if (avg_vld) begin
      phase_rb <= avg_val;
    end
  end

  // ==========================================================================
  // Input level faults
  logic [LVL_FLAGS-1:0] level_stat;
  logic [LVL_FLAGS-1:0] next_level_stat;

  assign next_level_stat = {|level_q.frame_hi, |level_q.frame_lo,
                            |level_q.dclk_hi, |level_q.dclk_lo,
                            |level_q.data_hi, |level_q.data_lo};

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      level_stat <= '0;
    end else begin
      level_stat <= next_level_stat;
    end
  end

  // ==========================================================================
  // Interrupts
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_event;
  logic [IRQ_W-1:0] next_irq_stat;
  logic irq_clr;

  always_comb begin
    irq_event = '0;
    irq_event[IRQ_LOCK_BIT] = (lock_state == LK_IDLE) && (next_lock_state == LK_LOCKED);
    irq_event[IRQ_LOST_BIT] = (lock_state == LK_LOCKED) && (next_lock_state == LK_LOST);
    irq_event[IRQ_RB_BIT] = avg_vld;
    irq_event[IRQ_LVL_BIT] = |(next_level_stat & ~level_stat);
  end

  // A read clears the flags, but an event in the same cycle survives it.
  assign irq_clr = i_bus.rd && (i_bus.addr == OFF_IRQ_STAT);
  assign next_irq_stat = (irq_clr ? '0 : irq_stat) | irq_event;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_stat <= '0;
      o_irq <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      o_irq <= |(next_irq_stat & irq_mask);
    end
  end

  // ==========================================================================
  // Register read port
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= '0;
    end else if (i_bus.rd) begin
      case (i_bus.addr)
        OFF_SYNC_CTRL: o_rdata <= {sync_en, rate_sel, 3'h0, avg_code} | {4'h0, rise_sel, 3'h0};
        OFF_PHASE_REQ: o_rdata <= {2'h0, phase_req};
        OFF_LOCK_STAT: o_rdata <= {lock_state == LK_LOST, lock_state == LK_LOCKED, 6'h00};
        OFF_PHASE_RB: o_rdata <= phase_rb;
        OFF_LEVEL_STAT: o_rdata <= {2'h0, level_stat};
        OFF_IRQ_STAT: o_rdata <= {4'h0, irq_stat};
        OFF_IRQ_MASK: o_rdata <= {4'h0, irq_mask};
        default: o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

  // ==========================================================================
  // Checks
  AST_OFF_NO_LOCK: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !sync_en |=> !o_sync_locked && (lock_state == LK_IDLE))
    else $error("lock held while sync disabled");
  AST_EDGE_SELECT: assert property (@(posedge i_clk) disable iff (!i_resetn)
    sync_en && (lock_state == LK_IDLE) && rise_sel && sync_fall |=> lock_state == LK_IDLE)
    else $error("falling edge started sync in rising mode");
  AST_REQ_WRITE_ONLY: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !$stable(phase_req) |-> $past(wr_req))
    else $error("phase request changed without write");
  AST_ALIGN_OFFSET: assert property (@(posedge i_clk) disable iff (!i_resetn)
    sync_edge && (lock_state == LK_IDLE) |=> (phase_cnt == $past(phase_req)) ##1 phase_cnt == $past(phase_req) + 6'h01)
    else $error("phase counter not aligned to request");
  AST_LOCK_SET: assert property (@(posedge i_clk) disable iff (!i_resetn)
    sync_edge && (lock_state == LK_IDLE) |=> o_sync_locked && (lock_state == LK_LOCKED))
    else $error("lock not taken at first sync edge");
  AST_LOST_CAUSE: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (lock_state == LK_LOST) && ($past(lock_state) != LK_LOST) |-> $past(phase_miss) && $past(sync_en))
    else $error("lost without mismatch after lock");
  AST_RB_WINDOW: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !$stable(phase_rb) |-> $past(avg_vld))
    else $error("readback changed without full window");
  AST_LEVEL_READ: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_bus.rd && (i_bus.addr == OFF_LEVEL_STAT) |=> o_rdata == {2'h0, $past(level_stat)})
    else $error("level status read wrong");
  AST_IRQ_SET_WINS: assert property (@(posedge i_clk) disable iff (!i_resetn)
    irq_clr && avg_vld |=> irq_stat[IRQ_RB_BIT])
    else $error("event lost under read clear");
  AST_LOCK_STAT_READ: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_bus.rd && (i_bus.addr == OFF_LOCK_STAT) |=> (o_rdata[STAT_LOCK_BIT] == $past(o_sync_locked))
      && (o_rdata[STAT_LOST_BIT] == ($past(lock_state) == LK_LOST)))
    else $error("lock status read wrong");
  AST_STROBE_SKEW: assert property (@(posedge i_clk) disable iff (!i_resetn)
    sync_edge && (lock_state == LK_IDLE) && (phase_req == 6'h3F) |-> ##2 !o_frame_strobe ##1 o_frame_strobe)
    else $error("frame strobe not skewed by full request");
  AST_DCLK_FLAGS: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (level_q.dclk_hi != '0) |=> level_stat[3])
    else $error("data clock high flag missing");
  AST_DATA_FLAGS: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (level_q.data_lo != '0) |=> level_stat[0])
    else $error("data low flag missing");
  AST_RB_QUARTER: assert property (@(posedge i_clk) disable iff (!i_resetn)
    avg_vld && ($past(avg_code) == 3'h0) |=> phase_rb[1:0] == 2'b00)
    else $error("single sample readback has fraction");
endmodule // msp_top
`default_nettype wire

//--- verif/msp_sync_source.sv
// Model of the external sync pulse source shared by several converters.
// Assumes it runs off the same sample clock as the block under test.
`timescale 1ns/100ps
`default_nettype none
module msp_sync_source #(
  parameter int PERIOD = 64,
  parameter int HIGH_LEN = 16
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_run,
  output logic o_sync
);
  // ==========================================================================
  // Pulse train
  // The period is a whole multiple of the phase counter length, so every
  // converter sharing this pulse sees the same phase on each edge.
  int cnt;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt <= 0;
      o_sync <= 1'b0;
    end else if (!i_run) begin
      cnt <= 0;
      o_sync <= 1'b0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      o_sync <= (cnt < HIGH_LEN);
    end
  end
endmodule // msp_sync_source
`default_nettype wire

//--- verif/msp_top_test.sv
// Self-checking bench for the sync phase monitor top.
// Assumes the sync source model and the design package are compiled first.
`timescale 1ns/100ps
`default_nettype none
module msp_top_test import msp_pkg::*; ;
  // ==========================================================================
  // Signals and instances
  localparam int LVL_POS [6] = '{39, 36, 35, 32, 31, 0};
  logic i_clk;
  logic i_resetn;
  logic sync_run;
  logic sync_pin;
  logic irq;
  logic strobe;
  logic locked;
  logic [7:0] rdata;
  logic [7:0] d;
  msp_bus_req_s bus;
  msp_level_s lv;
  int bad_count;
  int check_count;

  msp_top uut (.i_clk(i_clk), .i_resetn(i_resetn), .i_bus(bus), .o_rdata(rdata), .o_irq(irq),
    .i_sync(sync_pin), .i_level(lv), .o_frame_strobe(strobe), .o_sync_locked(locked));
  msp_sync_source src (.i_clk(i_clk), .i_resetn(i_resetn), .i_run(sync_run), .o_sync(sync_pin));

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // ==========================================================================
  // Bus and check helpers
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk);
    bus.addr <= a;
    bus.wdata <= v;
    bus.wr <= 1'b1;
    @(posedge i_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge i_clk);
    bus.rd <= 1'b0;
    @(posedge i_clk);
    v = rdata;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v, exp);
  endtask
  task automatic wait_lock();
    int n;
    n = 0;
    while (locked !== 1'b1 && n < 200) begin
      @(posedge i_clk);
      n++;
    end
    chk({7'h00, locked}, 8'h01);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    rdc(OFF_SYNC_CTRL, RST_SYNC_CTRL);
    rdc(OFF_PHASE_REQ, 8'h00);
    rdc(OFF_IRQ_MASK, 8'h00);
    rdc(OFF_LOCK_STAT, 8'h00);
    rdc(8'h20, 8'h00);
    wr(OFF_LOCK_STAT, 8'hFF);
    rdc(OFF_LOCK_STAT, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_request();
    wr(OFF_PHASE_REQ, 8'hFF);
    rdc(OFF_PHASE_REQ, 8'h3F);
    wr(OFF_PHASE_REQ, 8'h05);
    rdc(OFF_PHASE_REQ, 8'h05);
    $display("test request done");
  endtask
  task automatic t_disabled();
    sync_run <= 1'b1;
    repeat (200) @(posedge i_clk);
    chk({7'h00, locked}, 8'h00);
    rdc(OFF_LOCK_STAT, 8'h00);
    $display("test disabled done");
  endtask
  // Each averaging code must hold the readback back until its full window of samples is in.
  task automatic t_windows();
    for (int c = 0; c < 8; c++) begin
      wr(OFF_SYNC_CTRL, 8'h08 | 8'(c));
      rd(OFF_IRQ_STAT, d);
      wr(OFF_SYNC_CTRL, 8'h88 | 8'(c));
      wait_lock();
      chk({7'h00, sync_pin}, 8'h01);
      rdc(OFF_LOCK_STAT, 8'h40);
      rd(OFF_IRQ_STAT, d);
      repeat (64 * (1 << c) - 35) @(posedge i_clk);
      rd(OFF_IRQ_STAT, d);
      chk(d & 8'h04, 8'h00);
      repeat (64) @(posedge i_clk);
      rd(OFF_IRQ_STAT, d);
      chk(d & 8'h04, 8'h04);
      rdc(OFF_PHASE_RB, 8'h14);
    end
    $display("test windows done");
  endtask
  task automatic t_falling();
    wr(OFF_SYNC_CTRL, 8'h00);
    wr(OFF_PHASE_REQ, 8'h3F);
    wr(OFF_SYNC_CTRL, 8'h80);
    wait_lock();
    chk({7'h00, sync_pin}, 8'h00);
    // A full request of 63 puts the counter at zero one cycle after lock shows.
    repeat (2) @(posedge i_clk);
    chk({7'h00, strobe}, 8'h01);
    @(posedge i_clk);
    chk({7'h00, strobe}, 8'h00);
    rdc(OFF_LOCK_STAT, 8'h40);
    repeat (100) @(posedge i_clk);
    rdc(OFF_PHASE_RB, 8'hFC);
    $display("test falling done");
  endtask
  task automatic t_lost();
    wr(OFF_SYNC_CTRL, 8'h00);
    wr(OFF_PHASE_REQ, 8'h05);
    wr(OFF_IRQ_MASK, 8'h02);
    wr(OFF_SYNC_CTRL, 8'h88);
    wait_lock();
    rd(OFF_IRQ_STAT, d);
    chk({7'h00, irq}, 8'h00);
    wr(OFF_PHASE_REQ, 8'h07);
    repeat (200) @(posedge i_clk);
    rdc(OFF_LOCK_STAT, 8'h80);
    chk({7'h00, locked}, 8'h00);
    chk({7'h00, irq}, 8'h01);
    rd(OFF_IRQ_STAT, d);
    chk(d & 8'h02, 8'h02);
    rd(OFF_IRQ_STAT, d);
    chk(d & 8'h02, 8'h00);
    repeat (2) @(posedge i_clk);
    chk({7'h00, irq}, 8'h00);
    $display("test lost done");
  endtask
  task automatic t_level();
    logic [LVL_W-1:0] t;
    for (int i = 0; i < 6; i++) begin
      t = '0;
      t[LVL_POS[i]] = 1'b1;
      lv <= t;
      repeat (6) @(posedge i_clk);
      rdc(OFF_LEVEL_STAT, 8'h20 >> i);
    end
    lv <= '0;
    repeat (6) @(posedge i_clk);
    rdc(OFF_LEVEL_STAT, 8'h00);
    rd(OFF_IRQ_STAT, d);
    chk(d & 8'h08, 8'h08);
    $display("test level done");
  endtask

  // ==========================================================================
  // Sequence, watchdog and verdict
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    bus = '0;
    lv = '0;
    sync_run = 1'b0;
    i_resetn = 1'b0;
    bad_count = 0;
    check_count = 0;
    repeat (5) @(posedge i_clk);
    i_resetn <= 1'b1;
    t_reset();
    t_request();
    t_disabled();
    t_windows();
    t_falling();
    t_lost();
    t_level();
    close_out();
  end

  // The full run needs about 90 us; this allows a wide margin before cutting a hang.
  initial begin
    #400000;
    bad_count++;
    close_out();
  end
endmodule // msp_top_test
`default_nettype wire
